// ---- dv/uefa_checker.sv ----
// Checker for the endpoint FIFO access block, bound to its top.
// Assumes inputs change away from the rising clock edge.
`timescale 1ns/100ps
module uefa_checker (
    // Clock and reset
    input wire logic       i_sys_clk,
    input wire logic       i_rst_b,
    // MCU register port
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // SIE side
    input wire logic       i_host_busy,
    input wire logic       i_host_pipe,
    input wire logic       i_host_done,
    input wire logic       i_host_setup,
    input wire logic       i_host_zero_len,
    input wire logic       i_host_wr_valid,
    input wire logic [7:0] i_host_wr_data,
    input wire logic [1:0] o_host_full,
    input wire logic       i_host_rd_req,
    input wire logic       o_host_rd_valid,
    input wire logic [7:0] o_host_rd_data,
    input wire logic [1:0] o_host_packet_ready,
    input wire logic       o_usb_int,
    input wire logic       o_active_pipe_number,
    input wire logic [1:0] o_pipe_accessed
);
    logic [4:0] sh_ff;
    wire logic  cmd_rd = i_reg_rd && i_reg_addr == 8'h46;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // Shadow of stored command bits
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh_ff <= 5'h00;
        end else if (i_reg_wr && i_reg_addr == 8'h46) begin
            sh_ff <= i_reg_wdata[4:0];
        end
    end
    usb_int_a: assert property (o_usb_int == $past(i_host_done))
        else $error("usb interrupt not one cycle after host done");
    pipe_num_a: assert property (i_host_done |=> o_active_pipe_number == $past(i_host_pipe))
        else $error("active pipe number wrong");
    acc_set_a: assert property (i_host_done && !i_reg_wr |=> o_pipe_accessed[$past(i_host_pipe)])
        else $error("accessed bit not set");
    acc_cause_a: assert property ($rose(o_pipe_accessed[0]) |-> $past(i_host_done && !i_host_pipe))
        else $error("accessed bit set without access");
    rd_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data not idle");
    unmapped_read_a: assert property (i_reg_rd && !(i_reg_addr inside {8'h46, 8'h48, 8'h49})
        |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    rdy_idle_a: assert property (cmd_rd && !sh_ff[0] && !$past(sh_ff[0]) |=> !o_reg_rdata[6])
        else $error("ready without request");
    rdy_busy_a: assert property (cmd_rd && i_host_busy && $past(i_host_busy) && $stable(i_host_pipe)
        && $stable(sh_ff) && i_host_pipe == sh_ff[3] && !sh_ff[4] |=> !o_reg_rdata[6])
        else $error("ready while host busy");
    pipe1_commit_a: assert property ($rose(o_host_packet_ready[1]) |-> $past(i_reg_wr && i_reg_addr == 8'h46
        && !i_reg_wdata[1] && sh_ff == 5'h0b)) else $error("pipe 1 commit without tx end");
    pipe0_commit_a: assert property ($rose(o_host_packet_ready[0]) |-> $past(i_reg_wr && i_reg_addr == 8'h46
        && !i_reg_wdata[1] && sh_ff == 5'h03)) else $error("pipe 0 commit without tx end");
    done_clr_a: assert property (i_host_done |=> !o_host_packet_ready[$past(i_host_pipe)])
        else $error("packet ready kept after host done");
endmodule
bind uefa_top uefa_checker u_uefa_checker (.*);

// ---- dv/uefa_host_model.sv ----
// Host-side SIE model: moves packets into and out of the endpoint FIFOs.
// Assumes the bench calls its tasks; drives at the falling clock edge.
`timescale 1ns/100ps
module uefa_host_model (
    // Clock
    input  wire logic       i_sys_clk,
    // To block
    output logic            o_busy,
    output logic            o_pipe,
    output logic            o_done,
    output logic            o_setup,
    output logic            o_zero_len,
    output logic            o_wr_valid,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_req,
    // From block
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data
);
    logic [7:0] got [$];
    initial begin
        {o_busy, o_pipe, o_done, o_setup, o_zero_len, o_wr_valid, o_rd_req} = '0;
        o_wr_data = 8'h5a;
    end
    // Claim or release a pipe; release ends with done
    task automatic hold(input logic p, input logic on);
        @(negedge i_sys_clk);
        o_pipe = p;
        o_busy = on;
        o_done = !on;
        @(negedge i_sys_clk);
        o_done = 1'b0;
    endtask
    task automatic put(input logic p, input logic stp, input int n, input logic [7:0] b);
        hold(p, 1'b1);
        o_setup = stp;
        o_zero_len = (n == 0);
        @(negedge i_sys_clk);
        {o_setup, o_zero_len} = '0;
        for (int i = 0; i < n; i++) begin
            o_wr_valid = 1'b1;
            o_wr_data = b + 8'(i);
            @(negedge i_sys_clk);
            o_wr_valid = 1'b0;
            o_wr_data = ~o_wr_data;
            @(negedge i_sys_clk);
        end
        hold(p, 1'b0);
    endtask
    task automatic take(input logic p, input int n);
        got.delete();
        hold(p, 1'b1);
        for (int i = 0; i < n; i++) begin
            o_rd_req = 1'b1;
            @(negedge i_sys_clk);
            if (i_rd_valid === 1'b1) got.push_back(i_rd_data);
            o_rd_req = 1'b0;
            @(negedge i_sys_clk);
        end
        hold(p, 1'b0);
    endtask
endmodule

// ---- dv/usb_endpoint_fifo_access_bench.sv ----
// Self-checking bench for the endpoint FIFO access block.
// Assumes the host model drives the SIE side; 25 MHz clock.
`timescale 1ns/100ps
module usb_endpoint_fifo_access_bench;
    localparam int GAP = 50;
    logic       clk, rst_b, rwr, rrd, busy, pipe, done, stp, zl, hwv, hrq, hrv, irq, act;
    logic [7:0] addr, wdat, rdat, hwd, hrd, v;
    logic [1:0] full, pkt, acc;
    int         fails, checks, cyc, n;
    uefa_top u_uefa_top (.i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_wr(rwr), .i_reg_rd(rrd), .i_reg_addr(addr),
        .i_reg_wdata(wdat), .o_reg_rdata(rdat), .i_host_busy(busy), .i_host_pipe(pipe), .i_host_done(done),
        .i_host_setup(stp), .i_host_zero_len(zl), .i_host_wr_valid(hwv), .i_host_wr_data(hwd), .o_host_full(full),
        .i_host_rd_req(hrq), .o_host_rd_valid(hrv), .o_host_rd_data(hrd), .o_host_packet_ready(pkt),
        .o_usb_int(irq), .o_active_pipe_number(act), .o_pipe_accessed(acc));
    uefa_host_model u_uefa_host_model (.i_sys_clk(clk), .o_busy(busy), .o_pipe(pipe), .o_done(done),
        .o_setup(stp), .o_zero_len(zl), .o_wr_valid(hwv), .o_wr_data(hwd), .o_rd_req(hrq),
        .i_rd_valid(hrv), .i_rd_data(hrd));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Register access, then a 2 us gap
    task automatic acc_reg(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {rwr, rrd} = {w, !w};
        addr = a;
        wdat = d;
        @(negedge clk);
        {rwr, rrd} = 2'b00;
        v = rdat;
        repeat (GAP) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc_reg(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        acc_reg(1'b0, a, 8'h00);
        chk(v, e);
    endtask
    task automatic t_regs();
        rc(8'h46, 8'h00);
        rc(8'h40, 8'h00);
        $display("register test done");
    endtask
    task automatic t_zero_length_flag();
        u_uefa_host_model.put(1'b0, 1'b0, 0, 8'h00);
        rc(8'h46, 8'h80);
        rc(8'h48, 8'h00);
        rc(8'h46, 8'h00);
        u_uefa_host_model.put(1'b0, 1'b0, 0, 8'h00);
        $display("zero length test done");
    endtask
    task automatic t_ctrl_rd();
        u_uefa_host_model.put(1'b0, 1'b1, 8, 8'h10);
        chk({6'h00, full}, 8'h01);
        rc(8'h46, 8'h20);
        wr(8'h46, 8'h00);
        wr(8'h46, 8'h01);
        rc(8'h46, 8'h41);
        for (int i = 0; i < 8; i++) rc(8'h48, 8'h10 + 8'(i));
        rc(8'h46, 8'h01);
        wr(8'h46, 8'h03);
        wr(8'h46, 8'h02);
        wr(8'h46, 8'h00);
        $display("control read test done");
    endtask
    task automatic t_intr_wr();
        wr(8'h46, 8'h0a);
        wr(8'h46, 8'h0b);
        rc(8'h46, 8'h4b);
        n = 0;
        while (v[6] === 1'b1 && n < 9) begin
            wr(8'h49, 8'h30 + 8'(n));
            n++;
            acc_reg(1'b0, 8'h46, 8'h00);
        end
        chk(8'(n), 8'h08);
        chk(v, 8'h0b);
        wr(8'h46, 8'h09);
        chk({6'h00, pkt}, 8'h02);
        wr(8'h46, 8'h08);
        u_uefa_host_model.take(1'b1, 8);
        for (int i = 0; i < 8; i++) chk(u_uefa_host_model.got[i], 8'h30 + 8'(i));
        chk({5'h00, act, pkt}, 8'h04);
        $display("interrupt write test done");
    endtask
    task automatic t_intr_rd();
        u_uefa_host_model.put(1'b1, 1'b0, 1, 8'h60);
        wr(8'h46, 8'h08);
        wr(8'h46, 8'h09);
        rc(8'h46, 8'h49);
        rc(8'h48, 8'h00);
        rc(8'h49, 8'h60);
        rc(8'h46, 8'h09);
        wr(8'h46, 8'h0b);
        wr(8'h46, 8'h0a);
        $display("interrupt read test done");
    endtask
    task automatic t_clear();
        u_uefa_host_model.put(1'b0, 1'b0, 3, 8'h70);
        wr(8'h46, 8'h00);
        wr(8'h46, 8'h01);
        rc(8'h46, 8'h41);
        wr(8'h46, 8'h05);
        rc(8'h46, 8'h05);
        wr(8'h46, 8'h00);
        $display("clear test done");
    endtask
    task automatic t_busy();
        u_uefa_host_model.put(1'b0, 1'b0, 2, 8'h50);
        u_uefa_host_model.hold(1'b0, 1'b1);
        wr(8'h46, 8'h01);
        rc(8'h46, 8'h01);
        u_uefa_host_model.hold(1'b0, 1'b0);
        rc(8'h46, 8'h41);
        rc(8'h48, 8'h50);
        wr(8'h46, 8'h05);
        wr(8'h46, 8'h00);
        $display("host busy test done");
    endtask
    task automatic t_zero_send();
        wr(8'h46, 8'h02);
        wr(8'h46, 8'h03);
        rc(8'h46, 8'h43);
        wr(8'h46, 8'h01);
        wr(8'h46, 8'h00);
        chk({6'h00, pkt}, 8'h01);
        u_uefa_host_model.take(1'b0, 0);
        chk({5'h00, act, pkt}, 8'h00);
        $display("zero send test done");
    endtask
    initial begin
        {rst_b, rwr, rrd} = 3'b000;
        addr = 8'h00;
        wdat = 8'h00;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        t_regs();
        t_zero_length_flag();
        t_ctrl_rd();
        t_intr_wr();
        t_intr_rd();
        t_clear();
        t_busy();
        t_zero_send();
        report_and_stop();
    end
endmodule

// ---- inc/uefa_pkg.sv ----
// Package for the endpoint FIFO access block: register map, field layout,
// reset values and carrier types.
// Assumes an 8-bit MCU register port and a same-clock SIE on the host side.
package uefa_pkg;

    // Register offsets on the MCU register port
    localparam logic [7:0] UEFA_OFS_CMD_STATUS = 8'h46;
    localparam logic [7:0] UEFA_OFS_CTRL_DATA  = 8'h48;
    localparam logic [7:0] UEFA_OFS_INTR_DATA  = 8'h49;

    // Field positions of fifo_command_status
    localparam int UEFA_BIT_REQUEST  = 0;
    localparam int UEFA_BIT_TX       = 1;
    localparam int UEFA_BIT_CLEAR    = 2;
    localparam int UEFA_BIT_SEL_LOW  = 3;
    localparam int UEFA_BIT_SEL_HIGH = 4;
    localparam int UEFA_BIT_SETUP    = 5;
    localparam int UEFA_BIT_READY    = 6;
    localparam int UEFA_BIT_ZERO_LENGTH_FLAG     = 7;

    // Endpoint FIFO geometry
    localparam int UEFA_DATA_W   = 8;
    localparam int UEFA_FIFO_D   = 8;
    localparam int UEFA_NUM_PIPE = 2;

    // Pipe selection codes
    localparam logic [1:0] UEFA_SEL_CTRL = 2'h0;
    localparam logic [1:0] UEFA_SEL_INTR = 2'h1;

    // Reset values
    localparam logic [7:0] UEFA_RST_CMD   = 8'h00;
    localparam logic [7:0] UEFA_RST_BYTE  = 8'h00;
    localparam logic [1:0] UEFA_RST_PIPES = 2'h0;

    // Command/status register fields; ready is read-only
    typedef struct packed {
        logic       zero_length_flag;
        logic       ready;
        logic       setup_flag;
        logic       fifo_select_high;
        logic       fifo_select_low;
        logic       clear;
        logic       tx;
        logic       request;
    } uefa_cmd_t;

    // MCU register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uefa_reg_req_t;

    // SIE side events and data
    typedef struct packed {
        logic       busy;
        logic       pipe;
        logic       done;
        logic       setup;
        logic       zero_len;
        logic       wr_valid;
        logic [7:0] wr_data;
        logic       rd_req;
    } uefa_sie_req_t;

endpackage

// ---- src/uefa_fifo.sv ----
// Parameterised synchronous FIFO with valid/ready on both sides and clear.
// Assumes one clock; clear has priority over push and pop.
`timescale 1ns/100ps
module uefa_fifo
    import uefa_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_b,
    // Flush
    input  wire logic             i_clr,
    // Fill side
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // Drain side
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
    } uefa_fifo_st_t;

    uefa_fifo_st_t    st_ff;
    uefa_fifo_st_t    nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;

    assign o_wr_ready = (st_ff.count != (AW+1)'(DEPTH));
    assign o_rd_valid = (st_ff.count != '0);
    assign o_rd_data  = mem_ff[st_ff.rptr];
    assign push       = i_wr_valid & o_wr_ready & ~i_clr;
    assign pop        = i_rd_ready & o_rd_valid & ~i_clr;

    always_comb begin
        nxt_st = st_ff;
        if (i_clr) begin
            nxt_st = '0;
        end else begin
            if (push) begin
                nxt_st.wptr = (st_ff.wptr == AW'(DEPTH-1)) ? '0 : st_ff.wptr + 1'b1;
            end
            if (pop) begin
                nxt_st.rptr = (st_ff.rptr == AW'(DEPTH-1)) ? '0 : st_ff.rptr + 1'b1;
            end
            nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage has no reset
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_ff[st_ff.wptr] <= i_wr_data;
        end
    end

endmodule

// ---- src/uefa_top.sv ----
// Notes on behaviour
// [RULE1] Request bit 0 claims the selected FIFO; firmware drops it when done.
// [RULE2] Direction bit 1: one means firmware writes, zero means firmware reads.
// [RULE3] Firmware inverts direction before dropping request to mark transfer end.
// [RULE4] Clear bit 2 empties the requested FIFO even when not ready.
// [RULE5] Select bits 4:3: 00 control FIFO, 01 interrupt FIFO.
// [RULE6] Setup flag bit 5 set on SETUP data; firmware clears it.
// [RULE7] Read-only ready bit 6 high when selected FIFO allows requested access.
// [RULE8] Zero-length bit 7 set when host sends a zero-byte packet.
// [RULE9] Zero-length cleared by firmware reading that FIFO or next SETUP token.
// [RULE10] Two 8x8 bidirectional FIFOs, each behind its own data port.
// [RULE11] Read request: ready high while data remains, low once packet drained.
// [RULE12] Firmware reads: select, tx 0, request, poll, read, tx 1, drop request.
// [RULE13] Write request: ready drops when FIFO accepts no more bytes.
// [RULE14] Firmware writes: select, tx 1, request, poll, write, tx 0, drop.
// [RULE15] Packets hold at most eight bytes; firmware counts bytes itself.
// [RULE16] Firmware waits two microseconds after request before polling ready.
// [RULE17] Firmware spaces data port accesses by at least two microseconds.
// [RULE18] Control FIFO read: 00h, 01h, wait 41h, read to 01h, 03h, 02h.
// [RULE19] Interrupt FIFO write: 0Ah, 0Bh, wait 4Bh, write to 0Bh, 09h, 08h.
// [RULE20] Readability test: 00h, 01h, read 41h or 01h, then 00h.
// [RULE21] Zero-byte send: 02h, 03h, wait 43h, 01h, 00h.
// [RULE22] Host-busy pipe is blocked to firmware; finish raises interrupt and pipe number.
// [RULE23] Per-pipe accessed bits set only after host really accessed that pipe.
// [RULE24] Ready low while request low or host transaction runs on that pipe.
//
// Top of the endpoint FIFO access block: command/status and data ports.
// Assumes the SIE runs on i_sys_clk and drives its inputs from flip-flops.
`timescale 1ns/100ps
module uefa_top
    import uefa_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    // MCU register port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // SIE transaction status
    input  wire logic        i_host_busy,
    input  wire logic        i_host_pipe,
    input  wire logic        i_host_done,
    input  wire logic        i_host_setup,
    input  wire logic        i_host_zero_len,
    // SIE data into FIFO
    input  wire logic        i_host_wr_valid,
    input  wire logic [7:0]  i_host_wr_data,
    output logic      [1:0]  o_host_full,
    // SIE data out of FIFO
    input  wire logic        i_host_rd_req,
    output logic             o_host_rd_valid,
    output logic      [7:0]  o_host_rd_data,
    output logic      [1:0]  o_host_packet_ready,
    // Interrupt and pipe report
    output logic             o_usb_int,
    output logic             o_active_pipe_number,
    output logic      [1:0]  o_pipe_accessed
);

    typedef struct packed {
        uefa_cmd_t  cmd;
        logic       zero_length_flag_pipe;
        logic [1:0] committed;
        logic [7:0] rdata;
        logic [7:0] host_rd_data;
        logic       host_rd_valid;
        logic [1:0] host_full;
        logic       usb_int;
        logic       active_pipe_number;
        logic [1:0] pipe_acc;
    } uefa_st_t;

    uefa_st_t      st_ff;
    uefa_st_t      nxt_st;
    uefa_reg_req_t rq;
    uefa_sie_req_t sie;
    uefa_cmd_t     wcmd;

    logic [1:0]    sel;
    logic          sel_pipe;
    logic          sel_valid;
    logic          blocked;
    logic          rdy_now;
    logic          wr_cmd;
    logic          rd_port [UEFA_NUM_PIPE];
    logic          wr_port [UEFA_NUM_PIPE];
    logic          f_clr   [UEFA_NUM_PIPE];
    logic          f_wv    [UEFA_NUM_PIPE];
    logic          f_wr    [UEFA_NUM_PIPE];
    logic [7:0]    f_wd    [UEFA_NUM_PIPE];
    logic          f_rv    [UEFA_NUM_PIPE];
    logic          f_rr    [UEFA_NUM_PIPE];
    logic [7:0]    f_rd    [UEFA_NUM_PIPE];
    logic          mcu_push [UEFA_NUM_PIPE];
    logic          mcu_pop  [UEFA_NUM_PIPE];
    logic          host_pop [UEFA_NUM_PIPE];

    assign rq  = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};
    assign sie = '{busy: i_host_busy, pipe: i_host_pipe, done: i_host_done,
                   setup: i_host_setup, zero_len: i_host_zero_len,
                   wr_valid: i_host_wr_valid, wr_data: i_host_wr_data,
                   rd_req: i_host_rd_req};
    assign wcmd = uefa_cmd_t'(rq.wdata);

    // Pipe decode from select bits
    assign sel       = {st_ff.cmd.fifo_select_high, st_ff.cmd.fifo_select_low}; // [RULE5]
    assign sel_valid = (sel == UEFA_SEL_CTRL) || (sel == UEFA_SEL_INTR); // [RULE5]
    assign sel_pipe  = (sel == UEFA_SEL_INTR);
    assign blocked   = sie.busy & (sie.pipe == sel_pipe); // [RULE22]
    assign wr_cmd    = rq.wr & (rq.addr == UEFA_OFS_CMD_STATUS);

    // Ready for the requested access
    always_comb begin
        rdy_now = 1'b0;
        if (st_ff.cmd.request && sel_valid && !blocked) begin // [RULE24] [RULE1]
            if (st_ff.cmd.tx) begin // [RULE2]
                rdy_now = f_wr[sel_pipe] & ~st_ff.committed[sel_pipe]; // [RULE13]
            end else begin
                rdy_now = f_rv[sel_pipe]; // [RULE11]
            end
        end
    end

    // FIFO port steering
    always_comb begin
        for (int i = 0; i < UEFA_NUM_PIPE; i++) begin
            rd_port[i]  = rq.rd & (rq.addr == (i == 0 ? UEFA_OFS_CTRL_DATA : UEFA_OFS_INTR_DATA));
            wr_port[i]  = rq.wr & (rq.addr == (i == 0 ? UEFA_OFS_CTRL_DATA : UEFA_OFS_INTR_DATA));
            // Firmware moves bytes only through its own selected, ready FIFO
            mcu_push[i] = wr_port[i] & rdy_now & st_ff.cmd.tx & (sel_pipe == 1'(i)); // [RULE10] [RULE14]
            mcu_pop[i]  = rd_port[i] & rdy_now & ~st_ff.cmd.tx & (sel_pipe == 1'(i)); // [RULE10] [RULE12]
            host_pop[i] = sie.rd_req & (sie.pipe == 1'(i)) & st_ff.committed[i];
            f_clr[i]    = wr_cmd & wcmd.clear & st_ff.cmd.request & (sel_pipe == 1'(i)) & sel_valid; // [RULE4]
            f_wv[i]     = mcu_push[i] | (sie.wr_valid & (sie.pipe == 1'(i)) & ~mcu_push[i]);
            f_wd[i]     = mcu_push[i] ? rq.wdata : sie.wr_data;
            f_rr[i]     = mcu_pop[i] | host_pop[i];
        end
    end

    // Two endpoint FIFOs
    for (genvar g = 0; g < UEFA_NUM_PIPE; g++) begin : g_fifo
        uefa_fifo #(
            .WIDTH (UEFA_DATA_W),
            .DEPTH (UEFA_FIFO_D)
        ) u_fifo (
            .i_sys_clk  (i_sys_clk),
            .i_rst_b    (i_rst_b),
            .i_clr      (f_clr[g]),
            .i_wr_valid (f_wv[g]),
            .o_wr_ready (f_wr[g]),
            .i_wr_data  (f_wd[g]),
            .o_rd_valid (f_rv[g]),
            .i_rd_ready (f_rr[g]),
            .o_rd_data  (f_rd[g])
        ); // [RULE10] [RULE15]
    end

    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.usb_int       = 1'b0;
        nxt_st.host_rd_valid = 1'b0;
        nxt_st.rdata         = UEFA_RST_BYTE;

        // Command register write
        if (wr_cmd) begin
            nxt_st.cmd.request          = wcmd.request; // [RULE1]
            nxt_st.cmd.tx               = wcmd.tx; // [RULE2]
            nxt_st.cmd.clear            = wcmd.clear; // [RULE4]
            nxt_st.cmd.fifo_select_high = wcmd.fifo_select_high; // [RULE5]
            nxt_st.cmd.fifo_select_low  = wcmd.fifo_select_low;
            // Firmware writes can only clear the flags
            nxt_st.cmd.setup_flag       = st_ff.cmd.setup_flag & wcmd.setup_flag; // [RULE6]
            nxt_st.cmd.zero_length_flag = st_ff.cmd.zero_length_flag & wcmd.zero_length_flag;
            // Write end: tx falls under request, packet handed to host
            if (st_ff.cmd.request && st_ff.cmd.tx && !wcmd.tx && sel_valid) begin // [RULE3] [RULE21]
                nxt_st.committed[sel_pipe] = 1'b1;
            end
            // Raising request on a pipe acknowledges its access bit
            if (wcmd.request && !st_ff.cmd.request) begin
                nxt_st.pipe_acc[wcmd.fifo_select_low] = 1'b0;
            end
        end

        // Flushed FIFO loses any pending packet
        for (int i = 0; i < UEFA_NUM_PIPE; i++) begin
            if (f_clr[i]) begin
                nxt_st.committed[i] = 1'b0; // [RULE4]
            end
        end

        // Zero-length flag cleared by reading its FIFO
        if ((rd_port[0] && !st_ff.zero_length_flag_pipe) || (rd_port[1] && st_ff.zero_length_flag_pipe)) begin
            nxt_st.cmd.zero_length_flag = 1'b0; // [RULE9]
        end
        // Next valid SETUP clears it
        if (sie.setup) begin
            nxt_st.cmd.zero_length_flag = 1'b0; // [RULE9]
            nxt_st.cmd.setup_flag       = 1'b1; // [RULE6]
        end
        // Zero-byte packet from host; set wins over clear
        if (sie.zero_len) begin
            nxt_st.cmd.zero_length_flag = 1'b1; // [RULE8]
            nxt_st.zero_length_flag_pipe            = sie.pipe;
        end

        // Ready flag tracks the live condition
        nxt_st.cmd.ready = rdy_now; // [RULE7] [RULE24]

        // Register read data
        if (rq.rd) begin
            case (rq.addr)
                UEFA_OFS_CMD_STATUS: begin
                    nxt_st.rdata = st_ff.cmd; // [RULE7]
                end
                UEFA_OFS_CTRL_DATA: begin
                    nxt_st.rdata = mcu_pop[0] ? f_rd[0] : UEFA_RST_BYTE;
                end
                UEFA_OFS_INTR_DATA: begin
                    nxt_st.rdata = mcu_pop[1] ? f_rd[1] : UEFA_RST_BYTE;
                end
                default: begin
                    nxt_st.rdata = UEFA_RST_BYTE;
                end
            endcase
        end

        // Host drains a committed packet
        if (host_pop[sie.pipe] && f_rv[sie.pipe]) begin
            nxt_st.host_rd_valid = 1'b1;
            nxt_st.host_rd_data  = f_rd[sie.pipe];
        end
        for (int i = 0; i < UEFA_NUM_PIPE; i++) begin
            nxt_st.host_full[i] = ~f_wr[i];
        end

        // Host finished a transaction
        if (sie.done) begin
            nxt_st.usb_int            = 1'b1; // [RULE22]
            nxt_st.active_pipe_number           = sie.pipe; // [RULE22]
            nxt_st.pipe_acc[sie.pipe] = 1'b1; // [RULE23]
            nxt_st.committed[sie.pipe] = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff              <= '0;
            st_ff.cmd          <= uefa_cmd_t'(UEFA_RST_CMD);
            st_ff.committed    <= UEFA_RST_PIPES;
            st_ff.pipe_acc     <= UEFA_RST_PIPES;
            st_ff.host_full    <= UEFA_RST_PIPES;
            st_ff.rdata        <= UEFA_RST_BYTE;
            st_ff.host_rd_data <= UEFA_RST_BYTE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign o_reg_rdata          = st_ff.rdata;
    assign o_host_full          = st_ff.host_full;
    assign o_host_rd_valid      = st_ff.host_rd_valid;
    assign o_host_rd_data       = st_ff.host_rd_data;
    assign o_host_packet_ready  = st_ff.committed;
    assign o_usb_int            = st_ff.usb_int;
    assign o_active_pipe_number = st_ff.active_pipe_number;
    assign o_pipe_accessed      = st_ff.pipe_acc;

endmodule
